// ==== hw/decimal_multiply_sequencer.sv ====
// Decimal multiply sequencer: shift-and-add over a BCD accumulator
// Contract
// - Ten by ten digits into twenty-digit accumulator
// - Read multiplicand into distributor before cycles
// - Shift all but extra, count positions left
// - Add multiplicand digit times; zero means shift
// - Ten shift-add steps, count in count position
// - Product sign from both factor signs
// - First cycle is always a left shift
// - Each shift bumps count, starting from zero
// - Test extra digit zero to pick next cycle
// - Zero repeats shift, nonzero starts adds
// - Add nine to digit, store in extra
// - Nonzero reduced digit adds again, zero shifts
// - Count carry at ten sets end latch
module decimal_multiply_sequencer (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Instruction control
    input  wire logic        start,
    output logic             busy,
    output logic             done,
    // Storage read-in of the multiplicand
    output logic             read_req,
    input  wire logic        read_valid,
    input  wire logic [39:0] read_data,
    input  wire logic        read_sign,
    // Accumulator load and observation
    input  wire logic        acc_load,
    input  wire logic [39:0] acc_load_upper,
    input  wire logic [39:0] acc_load_lower,
    input  wire logic        acc_load_sign,
    output logic [39:0]      acc_upper,
    output logic [39:0]      acc_lower,
    output logic             acc_sign
);
    localparam int W = 4 * dmul_pkg::ACC_DIGITS;
    // Bit spans of the two ten-digit halves inside the store word
    localparam int HALF_W = 4 * dmul_pkg::DIGITS;
    localparam int LO_BIT = 4 * dmul_pkg::LOWER_LO;
    localparam int UP_BIT = LO_BIT + HALF_W;

    dmul_acc_if acc_bus ();

    dmul_acc_store u_store (
        .clk     (clk),
        .reset_n (reset_n),
        .acc     (acc_bus.mem)
    );

    dmul_pkg::seq_state_t state_ff, nxt_state;
    logic [39:0] dist_ff, nxt_dist;
    logic        dist_sign_ff, nxt_dist_sign;
    logic        sign_ff, nxt_sign;
    logic        end_ff, nxt_end;
    logic        busy_ff, nxt_busy;
    logic        done_ff, nxt_done;
    logic        req_ff, nxt_req;
    logic [39:0] up_ff, nxt_up;
    logic [39:0] lo_ff, nxt_lo;
    logic        wr;
    logic [W-1:0] wr_word;
    logic [W-1:0] cur;

    // One BCD digit add with carry
    function automatic logic [4:0] bcd_add(input logic [3:0] a, input logic [3:0] b,
                                          input logic ci);
        logic [4:0] s;
        s = {1'b0, a} + {1'b0, b} + {4'h0, ci};
        if (s > 5'd9) begin
            s = s + 5'd6;
        end
        return s;
    endfunction

    // Digit extraction from the accumulator word
    function automatic logic [3:0] dig(input logic [W-1:0] w, input int p);
        return w[4*p +: 4];
    endfunction

    assign cur = acc_bus.read_word;

    // Sequencer next state
    always_comb begin
        logic [W-1:0] sh;
        logic [4:0]   s;
        logic         c;
        logic [3:0]   red;
        sh = '0;
        s = '0;
        c = 1'b0;
        red = '0;
        nxt_state     = state_ff;
        nxt_dist      = dist_ff;
        nxt_dist_sign = dist_sign_ff;
        nxt_sign      = sign_ff;
        nxt_end       = end_ff;
        nxt_busy      = busy_ff;
        nxt_done      = 1'b0;
        nxt_req       = 1'b0;
        wr            = 1'b0;
        wr_word       = cur;
        case (state_ff)
            dmul_pkg::ST_IDLE: begin
                if (start) begin
                    nxt_state = dmul_pkg::ST_READ;
                    nxt_busy  = 1'b1;
                    nxt_req   = 1'b1;
                    nxt_end   = 1'b0;
                end
            end
            dmul_pkg::ST_READ: begin
                nxt_req = !read_valid;
                if (read_valid) begin
                    nxt_dist      = read_data;
                    nxt_dist_sign = read_sign;
                    nxt_state     = dmul_pkg::ST_SETUP;
                end
            end
            dmul_pkg::ST_SETUP: begin
                nxt_sign = sign_ff ^ dist_sign_ff;
                wr = 1'b1;
                wr_word[4*dmul_pkg::COUNT_POS +: 4] = dmul_pkg::ZERO_DIG;
                nxt_state = dmul_pkg::ST_SHIFT;
            end
            dmul_pkg::ST_SHIFT: begin
                sh = cur;
                for (int p = dmul_pkg::HIGH_POS; p > dmul_pkg::LOWER_LO; p--) begin
                    sh[4*p +: 4] = dig(cur, p - 1);
                end
                sh[4*dmul_pkg::LOWER_LO +: 4] = dmul_pkg::ZERO_DIG;
                sh[4*dmul_pkg::EXTRA_POS +: 4] = dig(cur, dmul_pkg::HIGH_POS);
                s = bcd_add(dig(cur, dmul_pkg::COUNT_POS), dmul_pkg::ONE_DIG, 1'b0);
                sh[4*dmul_pkg::COUNT_POS +: 4] = s[3:0];
                if (dig(cur, dmul_pkg::COUNT_POS) + dmul_pkg::ONE_DIG == dmul_pkg::END_COUNT) begin
                    nxt_end = 1'b1;
                end
                wr = 1'b1;
                wr_word = sh;
                if (dig(cur, dmul_pkg::HIGH_POS) != dmul_pkg::ZERO_DIG) begin
                    nxt_state = dmul_pkg::ST_ADD;
                end else if (nxt_end) begin
                    nxt_state = dmul_pkg::ST_DONE;
                end
            end
            dmul_pkg::ST_ADD: begin
                c = 1'b0;
                for (int i = 0; i < dmul_pkg::DIGITS; i++) begin
                    s = bcd_add(dig(cur, dmul_pkg::LOWER_LO + i), dist_ff[4*i +: 4], c);
                    wr_word[4*(dmul_pkg::LOWER_LO + i) +: 4] = s[3:0];
                    c = s[4];
                end
                // Carry out of the lower half ripples into the upper half
                for (int i = dmul_pkg::LOWER_LO + dmul_pkg::DIGITS; i <= dmul_pkg::HIGH_POS;
                     i++) begin
                    s = bcd_add(dig(cur, i), dmul_pkg::ZERO_DIG, c);
                    wr_word[4*i +: 4] = s[3:0];
                    c = s[4];
                end
                s = bcd_add(dig(cur, dmul_pkg::EXTRA_POS), dmul_pkg::NINE, 1'b0);
                red = s[3:0];
                wr_word[4*dmul_pkg::EXTRA_POS +: 4] = red;
                wr = 1'b1;
                if (red == dmul_pkg::ZERO_DIG) begin
                    nxt_state = end_ff ? dmul_pkg::ST_DONE : dmul_pkg::ST_SHIFT;
                end
            end
            dmul_pkg::ST_DONE: begin
                nxt_busy  = 1'b0;
                nxt_done  = 1'b1;
                nxt_state = dmul_pkg::ST_IDLE;
            end
            default: begin
                nxt_state = dmul_pkg::ST_IDLE;
                nxt_busy  = 1'b0;
            end
        endcase
        if (acc_load && state_ff == dmul_pkg::ST_IDLE) begin
            nxt_sign = acc_load_sign;
        end
    end

    assign acc_bus.load      = acc_load && state_ff == dmul_pkg::ST_IDLE;
    assign acc_bus.load_word = {acc_load_upper, acc_load_lower, 8'h00};
    assign acc_bus.write     = wr;
    assign acc_bus.write_word = wr_word;

    // Output copies registered so every output comes from a flip-flop
    always_comb begin
        nxt_up = wr ? wr_word[UP_BIT +: HALF_W] : cur[UP_BIT +: HALF_W];
        nxt_lo = wr ? wr_word[LO_BIT +: HALF_W] : cur[LO_BIT +: HALF_W];
        // A load only happens in idle, where the sequencer never writes
        if (acc_bus.load) begin
            nxt_up = acc_load_upper;
            nxt_lo = acc_load_lower;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff     <= dmul_pkg::ST_IDLE;
            dist_ff      <= '0;
            dist_sign_ff <= 1'b0;
            sign_ff      <= 1'b0;
            end_ff       <= 1'b0;
            busy_ff      <= 1'b0;
            done_ff      <= 1'b0;
            req_ff       <= 1'b0;
            up_ff        <= '0;
            lo_ff        <= '0;
        end else begin
            state_ff     <= nxt_state;
            dist_ff      <= nxt_dist;
            dist_sign_ff <= nxt_dist_sign;
            sign_ff      <= nxt_sign;
            end_ff       <= nxt_end;
            busy_ff      <= nxt_busy;
            done_ff      <= nxt_done;
            req_ff       <= nxt_req;
            up_ff        <= nxt_up;
            lo_ff        <= nxt_lo;
        end
    end

    assign busy      = busy_ff;
    assign done      = done_ff;
    assign read_req  = req_ff;
    assign acc_upper = up_ff;
    assign acc_lower = lo_ff;
    assign acc_sign  = sign_ff;
endmodule // decimal_multiply_sequencer

// ==== hw/dmul_pkg.sv ====
// Package: widths, digit positions and sequencer states for the decimal multiplier
package dmul_pkg;
    localparam int DIGITS      = 10;
    localparam int ACC_DIGITS  = 22;
    localparam int EXTRA_POS   = 0;
    localparam int COUNT_POS   = 1;
    localparam int LOWER_LO    = 2;
    localparam int HIGH_POS    = 21;
    localparam logic [3:0] NINE      = 4'h9;
    localparam logic [3:0] ZERO_DIG  = 4'h0;
    localparam logic [3:0] ONE_DIG   = 4'h1;
    localparam logic [3:0] END_COUNT = 4'ha;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_READ  = 3'b001,
        ST_SETUP = 3'b010,
        ST_SHIFT = 3'b011,
        ST_ADD   = 3'b100,
        ST_DONE  = 3'b101
    } seq_state_t;
endpackage

// ==== hw/dmul_acc_if.sv ====
// Interface: accumulator digit store command and read bundle
interface dmul_acc_if;
    logic        load;
    logic [87:0] load_word;
    logic        write;
    logic [87:0] write_word;
    logic [87:0] read_word;
    modport seq (output load, output load_word, output write, output write_word,
                 input read_word);
    modport mem (input load, input load_word, input write, input write_word,
                 output read_word);
endinterface

// ==== hw/dmul_acc_store.sv ====
// Accumulator digit store: 22 BCD digits, registered read data
module dmul_acc_store (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Accumulator access
    dmul_acc_if.mem  acc
);
    logic [87:0] word_ff;
    logic [87:0] nxt_word;

    // Load from the user side takes priority over the sequencer write
    always_comb begin
        nxt_word = word_ff;
        if (acc.load) begin
            nxt_word = acc.load_word;
        end else if (acc.write) begin
            nxt_word = acc.write_word;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            word_ff <= '0;
        end else begin
            word_ff <= nxt_word;
        end
    end

    assign acc.read_word = word_ff;
endmodule // dmul_acc_store

// ==== test/dmul_storage_model.sv ====
// Storage read-in partner: answers a multiplicand request after a set delay
module dmul_storage_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Request from the sequencer
    input  wire logic        read_req,
    // Stored word, its sign and the answer delay
    input  wire logic [39:0] word,
    input  wire logic        sign,
    input  wire logic [3:0]  delay,
    // Answer to the sequencer
    output logic             read_valid,
    output logic [39:0]      read_data,
    output logic             read_sign
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_cnt;

    // Data lines toggle outside the answer so stale values never pass as valid
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            read_valid <= 1'b0;
            read_data  <= 40'h0;
            read_sign  <= 1'b0;
            wait_cnt   <= 4'h0;
        end else begin
            read_valid <= 1'b0;
            read_data  <= ~read_data;
            read_sign  <= ~read_sign;
            if (read_req && !read_valid) begin
                if (wait_cnt == delay) begin
                    read_valid <= 1'b1;
                    read_data  <= word;
                    read_sign  <= sign;
                    wait_cnt   <= 4'h0;
                end else begin
                    wait_cnt <= wait_cnt + 4'h1;
                end
            end
        end
    end
endmodule // dmul_storage_model

// ==== test/dmul_checker.sv ====
// Checker: port-level properties of the decimal multiply sequencer
module dmul_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Control and read-in
    input wire logic start,
    input wire logic busy,
    input wire logic done,
    input wire logic read_req,
    input wire logic read_valid,
    input wire logic read_sign,
    // Accumulator
    input wire logic acc_load,
    input wire logic acc_load_sign,
    input wire logic acc_sign
);
    timeunit 1ns;
    timeprecision 1ps;
    logic mul_sign_ff;
    logic cand_sign_ff;
    logic nxt_mul_sign;
    logic nxt_cand_sign;
    // Idle is exactly busy low, the done cycle included
    wire logic idle_start = start && !busy;

    // Factor signs as the device takes them
    always_comb begin
        nxt_mul_sign  = (acc_load && !busy) ? acc_load_sign : mul_sign_ff;
        nxt_cand_sign = (read_valid && read_req) ? read_sign : cand_sign_ff;
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mul_sign_ff  <= 1'b0;
            cand_sign_ff <= 1'b0;
        end else begin
            mul_sign_ff  <= nxt_mul_sign;
            cand_sign_ff <= nxt_cand_sign;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_start_busy: assert property (idle_start |=> busy)
        else $error("busy not raised after start");
    a_start_read: assert property (idle_start |=> read_req)
        else $error("no multiplicand request after start");
    a_read_drop: assert property (read_req && read_valid |=> !read_req)
        else $error("request held after multiplicand taken");
    a_req_busy: assert property (read_req |-> busy)
        else $error("request outside a multiply");
    a_done_pulse: assert property (done |=> !done)
        else $error("done longer than one cycle");
    a_busy_end: assert property ($fell(busy) |-> done)
        else $error("busy dropped without done");
    a_run_bound: assert property ($rose(busy) |-> ##[12:400] done)
        else $error("multiply length out of range");
    a_sign_prod: assert property (done |-> acc_sign == (mul_sign_ff ^ cand_sign_ff))
        else $error("product sign wrong");

    c_start: cover property (idle_start);
    c_minus: cover property (done && acc_sign);
    c_refused: cover property (busy && start);
endmodule // dmul_checker

bind decimal_multiply_sequencer dmul_checker u_chk (.clk, .reset_n, .start, .busy, .done,
    .read_req, .read_valid, .read_sign, .acc_load, .acc_load_sign, .acc_sign);

// ==== test/tb_top.sv ====
// Testbench: multiplies known factors and compares product, sign and handshake
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, reset_n, start, busy, done, read_req, read_valid, read_sign;
    logic        acc_load, acc_load_sign, acc_sign, mem_sign;
    logic [39:0] read_data, mem_word;
    logic [39:0] acc_load_upper, acc_load_lower, acc_upper, acc_lower;
    logic [3:0]  mem_delay;
    int          err_count, checks_done;

    decimal_multiply_sequencer u_dut (.clk, .reset_n, .start, .busy, .done, .read_req,
        .read_valid, .read_data, .read_sign, .acc_load, .acc_load_upper, .acc_load_lower,
        .acc_load_sign, .acc_upper, .acc_lower, .acc_sign);
    dmul_storage_model u_mem (.clk, .reset_n, .read_req, .word(mem_word), .sign(mem_sign),
        .delay(mem_delay), .read_valid, .read_data, .read_sign);

    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check_val(string name, logic [79:0] seen, logic [79:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report;
        $display("mismatches %0d comparisons %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // One multiply; poke retries start and load while busy, which must be ignored
    task automatic run_mul(logic [39:0] mplier, logic ms, logic [39:0] mcand, logic cs,
                           logic [3:0] dly, logic poke, logic [39:0] eu, logic [39:0] el);
        int n;
        @(posedge clk);
        acc_load       <= 1'b1;
        acc_load_upper <= mplier;
        acc_load_lower <= 40'h0;
        acc_load_sign  <= ms;
        mem_word       <= mcand;
        mem_sign       <= cs;
        mem_delay      <= dly;
        @(posedge clk);
        acc_load <= 1'b0;
        start    <= 1'b1;
        @(posedge clk);
        start          <= poke;
        acc_load       <= poke;
        acc_load_upper <= 40'h0;
        @(posedge clk);
        start    <= 1'b0;
        acc_load <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 500) begin
            @(negedge clk);
            n++;
        end
        check_val("done", 80'(done), 80'h1);
        check_val("busy", 80'(busy), 80'h0);
        @(negedge clk);
        check_val("upper", 80'(acc_upper), 80'(eu));
        check_val("lower", 80'(acc_lower), 80'(el));
        check_val("sign", 80'(acc_sign), 80'(ms ^ cs));
    endtask

    // Many adds per digit, mixed digits, shift and add carries
    task automatic s_typical;
        run_mul(40'h5213874169, 1'b0, 40'h3179848209, 1'b0, 4'h0, 1'b0,
                40'h1657932843, 40'h8246013321);
    endtask

    // Every sign pair, prompt and slow storage, refused requests while busy
    task automatic s_signs;
        for (int i = 0; i < 4; i++) begin
            run_mul(40'h0000000009, i[1], 40'h9999999999, i[0], 4'(i * 3), i[0],
                    40'h0000000008, 40'h9999999991);
        end
    endtask

    // Zero digits force shifts; a zero last digit ends the run directly
    task automatic s_zero_digits;
        run_mul(40'h9000000000, 1'b1, 40'h9999999999, 1'b0, 4'h1, 1'b0,
                40'h8999999999, 40'h1000000000);
        run_mul(40'h0000000000, 1'b1, 40'h9999999999, 1'b0, 4'h2, 1'b1,
                40'h0000000000, 40'h0000000000);
    endtask

    // Main sequence
    initial begin
        reset_n        = 1'b0;
        start          = 1'b0;
        acc_load       = 1'b0;
        acc_load_upper = 40'h0;
        acc_load_lower = 40'h0;
        acc_load_sign  = 1'b0;
        mem_word       = 40'h0;
        mem_sign       = 1'b0;
        mem_delay      = 4'h0;
        err_count      = 0;
        checks_done    = 0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        s_typical;
        s_signs;
        s_zero_digits;
        final_report;
    end

    // Watchdog well beyond the expected run of about 260 cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        final_report;
    end
endmodule // tb_top
